// ===== cnr_map.svh
// Constant map for the counter signal routing block: sizes, selector codes, masks and timing.
`ifndef CNR_MAP_SVH
`define CNR_MAP_SVH

// Sizes of the block.
`define CNR_NCTR 4
`define CNR_NPFI 16
`define CNR_SEL_W 6
`define CNR_ROUTE_W 5
`define CNR_NTB 6

// Signal pool positions seen by every selector of a counter.
`define CNR_POOL_PFI 0
`define CNR_POOL_TB 16
`define CNR_POOL_AN_CMP 22
`define CNR_POOL_CHG_DET 23
`define CNR_POOL_AI_REF 24
`define CNR_POOL_AI_START 25
`define CNR_POOL_AO_SCLK 26
`define CNR_POOL_DI_SCLK 27
`define CNR_POOL_DI_REF 28
`define CNR_POOL_DO_SCLK 29
`define CNR_POOL_AI_SCLK 30
`define CNR_POOL_AI_CONV 31
`define CNR_POOL_TC 32
`define CNR_POOL_GATE 36
`define CNR_POOL_INT_OUT 40
`define CNR_POOL_SRC 44
`define CNR_POOL_OWN_GATE 48

// Legal choices of each selector, one bit per pool position.
`define CNR_MASK_SRC 64'h0000_00FF_00FF_FFFF
`define CNR_MASK_GATE 64'h0000_FF00_3FC0_FFFF
`define CNR_MASK_AUX 64'h0001_FFF0_03C0_FFFF
`define CNR_MASK_ENC 64'h0000_0000_0040_FFFF
`define CNR_MASK_ARM 64'h0000_0F00_03C0_FFFF
`define CNR_MASK_SCLK_INT 64'h0000_0000_EC80_0000
`define CNR_MASK_SCLK_EXT 64'h0000_0000_0040_FFFF
// Positions of the selecting counter itself among the other-counter entries.
`define CNR_MASK_SELF 64'h0000_1111_0000_0000

// Terminal output route codes; counter k adds k to the SRC, GATE, Z, SCLK and INT_OUT bases.
`define CNR_ROUTE_NONE 5'h00
`define CNR_ROUTE_SRC 5'h01
`define CNR_ROUTE_GATE 5'h05
`define CNR_ROUTE_Z 5'h09
`define CNR_ROUTE_SCLK 5'h0D
`define CNR_ROUTE_INT_OUT 5'h11
`define CNR_ROUTE_SQWAVE 5'h15

// Digital filter: a terminal level must hold this many clocks before it is accepted.
`define CNR_FILT_CYCLES 2'h3

`endif

// ===== cnr_pkg.sv
// Types shared by the counter signal routing block and its users.
`include "cnr_map.svh"

package cnr_pkg;

  // Application that a counter performs.
  typedef enum logic [2:0] {
    CNR_PULSE_GEN = 3'h0,
    CNR_ONE_TIME = 3'h1,
    CNR_TWO_TIME = 3'h2,
    CNR_EDGE_NB = 3'h3,
    CNR_EDGE_BUF = 3'h4,
    CNR_TWO_EDGE = 3'h5
  } cnr_mode_e;

  // What an active gate edge does while the counter runs.
  typedef enum logic [1:0] {
    CNR_GATE_NONE = 2'h0,
    CNR_GATE_START = 2'h1,
    CNR_GATE_STOP = 2'h2,
    CNR_GATE_LATCH = 2'h3
  } cnr_gate_act_e;

  // Arm state of a counter.
  typedef enum logic [2:0] {
    CNR_IDLE = 3'b001,
    CNR_WAIT = 3'b010,
    CNR_RUN = 3'b100
  } cnr_fsm_e;

  typedef logic [`CNR_SEL_W-1:0] cnr_sel_t;

  // Per-counter configuration from software.
  typedef struct packed {
    cnr_sel_t src_sel;
    logic src_fall;
    cnr_sel_t gate_sel;
    logic gate_fall;
    cnr_gate_act_e gate_act;
    cnr_sel_t aux_sel;
    cnr_sel_t a_sel;
    cnr_sel_t b_sel;
    cnr_sel_t z_sel;
    cnr_sel_t arm_sel;
    logic hardware_arm_input_en;
    logic sclk_ext;
    cnr_sel_t sclk_int_sel;
    cnr_sel_t sclk_ext_sel;
    logic sclk_fall;
    cnr_mode_e mode;
    logic dir_from_b;
    logic dir_up;
    logic start_req;
    logic out_toggle;
    logic out_pol;
  } cnr_cfg_s;

  // Internal timebases, triggers and events of the device.
  typedef struct packed {
    logic [`CNR_NTB-1:0] tb;
    logic an_cmp;
    logic chg_det;
    logic ai_ref;
    logic ai_start;
    logic ao_sclk;
    logic di_sclk;
    logic di_ref;
    logic do_sclk;
    logic ai_sclk;
    logic ai_conv;
    logic sqwave;
  } cnr_sys_s;

  // Per-counter signals from the counter core.
  typedef struct packed {
    logic terminal_count;
    logic gen_pulse;
    logic buf_full;
  } cnr_core_s;

  // Per-counter signals toward the counter core and software.
  typedef struct packed {
    logic src_tick;
    logic up;
    logic src_is_tb;
    logic gate_start;
    logic gate_stop;
    logic gate_latch;
    logic aux_edge;
    logic a;
    logic b;
    logic z;
    logic armed;
    logic run;
    logic sclk_tick;
    logic overflow;
    logic int_out;
  } cnr_out_s;

  // Per-counter internal state.
  typedef struct packed {
    cnr_fsm_e fsm;
    logic src_lvl;
    logic gate_lvl;
    logic aux_lvl;
    logic arm_lvl;
    logic sclk_lvl;
    logic tog;
  } cnr_ctr_s;

  // Whole state of the block.
  typedef struct packed {
    logic [`CNR_NPFI-1:0] pfi_m;
    logic [`CNR_NPFI-1:0] pfi_s;
    logic [`CNR_NPFI-1:0] pfi_f;
    logic [`CNR_NPFI-1:0][1:0] filt_cnt;
    cnr_ctr_s [`CNR_NCTR-1:0] ctr;
    cnr_out_s [`CNR_NCTR-1:0] out;
    logic [`CNR_NPFI-1:0] pfi_out;
    logic [`CNR_NPFI-1:0] pfi_oe_n;
  } cnr_state_s;

endpackage

// ===== cnr_routing.sv
// Input selection, arming and output routing for four general-purpose counters.
`timescale 1ns/1ps
`include "cnr_map.svh"

module cnr_routing
  import cnr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [`CNR_NPFI-1:0] i_pfi,
  input wire logic i_pfi_filt_en,
  input wire logic [`CNR_NPFI-1:0][`CNR_ROUTE_W-1:0] i_pfi_route,
  input wire cnr_sys_s i_sys,
  input wire cnr_cfg_s [`CNR_NCTR-1:0] i_cfg,
  input wire cnr_core_s [`CNR_NCTR-1:0] i_core,
  input wire logic [`CNR_NCTR-1:0] i_sw_arm,
  input wire logic [`CNR_NCTR-1:0] i_disarm,
  input wire logic [`CNR_NCTR-1:0] i_ovf_clear,
  output cnr_out_s [`CNR_NCTR-1:0] o_ctr,
  output logic [`CNR_NPFI-1:0] o_pfi_out,
  output logic [`CNR_NPFI-1:0] o_pfi_oe_n
);

  // Picks one pool bit; illegal codes and the counter's own slots among the other-counter entries read as low.
  function automatic logic pick(input logic [63:0] pool, input cnr_sel_t code,
                                input logic [63:0] mask, input logic [1:0] self);
    logic [63:0] legal;
    legal = mask & ~(`CNR_MASK_SELF << self);
    return pool[code] & legal[code];
  endfunction

  // Edge of a level against its previous value, rising or falling.
  function automatic logic edge_of(input logic now, input logic old, input logic fall);
    return fall ? (old & ~now) : (now & ~old);
  endfunction

  cnr_state_s s_q;
  cnr_state_s s_d;

  // Next-state logic for the whole block.
  always_comb
  begin
    logic [63:0] pool;
    logic src;
    logic gate;
    logic aux;
    logic arm;
    logic sclk;
    logic src_e;
    logic gate_e;
    logic arm_e;
    logic sclk_e;
    logic gate_wait;
    logic [1:0] self;
    logic [4:0] rt;
    pool = '0;
    src = 1'b0;
    gate = 1'b0;
    aux = 1'b0;
    arm = 1'b0;
    sclk = 1'b0;
    src_e = 1'b0;
    gate_e = 1'b0;
    arm_e = 1'b0;
    sclk_e = 1'b0;
    gate_wait = 1'b0;
    self = 2'h0;
    rt = 5'h00;
    s_d = s_q;
    // Two-flop synchroniser, then a hold filter; only the second flop feeds the filter.
    s_d.pfi_m = i_pfi;
    s_d.pfi_s = s_q.pfi_m;
    for (int p = 0; p < `CNR_NPFI; p++)
    begin
      if (!i_pfi_filt_en || s_q.pfi_s[p] == s_q.pfi_f[p])
      begin
        s_d.pfi_f[p] = s_q.pfi_s[p];
        s_d.filt_cnt[p] = 2'h0;
      end
      else if (s_q.filt_cnt[p] == `CNR_FILT_CYCLES - 2'h1)
      begin
        s_d.pfi_f[p] = s_q.pfi_s[p];
        s_d.filt_cnt[p] = 2'h0;
      end
      else
      begin
        s_d.filt_cnt[p] = s_q.filt_cnt[p] + 2'h1;
      end
    end
    for (int n = 0; n < `CNR_NCTR; n++)
    begin
      self = 2'(n);
      // Pool of candidate signals; other-counter gate, output and source entries are last cycle's levels, terminal counts are live.
      pool = '0;
      pool[`CNR_POOL_PFI +: `CNR_NPFI] = s_q.pfi_f;
      pool[`CNR_POOL_TB +: `CNR_NTB] = i_sys.tb;
      pool[`CNR_POOL_AN_CMP] = i_sys.an_cmp;
      pool[`CNR_POOL_CHG_DET] = i_sys.chg_det;
      pool[`CNR_POOL_AI_REF] = i_sys.ai_ref;
      pool[`CNR_POOL_AI_START] = i_sys.ai_start;
      pool[`CNR_POOL_AO_SCLK] = i_sys.ao_sclk;
      pool[`CNR_POOL_DI_SCLK] = i_sys.di_sclk;
      pool[`CNR_POOL_DI_REF] = i_sys.di_ref;
      pool[`CNR_POOL_DO_SCLK] = i_sys.do_sclk;
      pool[`CNR_POOL_AI_SCLK] = i_sys.ai_sclk;
      pool[`CNR_POOL_AI_CONV] = i_sys.ai_conv;
      for (int k = 0; k < `CNR_NCTR; k++)
      begin
        pool[`CNR_POOL_TC + k] = i_core[k].terminal_count;
        pool[`CNR_POOL_GATE + k] = s_q.ctr[k].gate_lvl;
        pool[`CNR_POOL_INT_OUT + k] = s_q.out[k].int_out;
        pool[`CNR_POOL_SRC + k] = s_q.ctr[k].src_lvl;
      end
      pool[`CNR_POOL_OWN_GATE] = s_q.ctr[n].gate_lvl;
      // Selectors, each with its legal set; a, b and z share the encoder set.
      src = pick(pool, i_cfg[n].src_sel, `CNR_MASK_SRC, self);
      gate = pick(pool, i_cfg[n].gate_sel, `CNR_MASK_GATE, self);
      aux = pick(pool, i_cfg[n].aux_sel, `CNR_MASK_AUX, self);
      arm = pick(pool, i_cfg[n].arm_sel, `CNR_MASK_ARM, self);
      s_d.out[n].a = pick(pool, i_cfg[n].a_sel, `CNR_MASK_ENC, self);
      s_d.out[n].b = pick(pool, i_cfg[n].b_sel, `CNR_MASK_ENC, self);
      s_d.out[n].z = pick(pool, i_cfg[n].z_sel, `CNR_MASK_ENC, self);
      if (i_cfg[n].sclk_ext)
      begin
        sclk = pick(pool, i_cfg[n].sclk_ext_sel, `CNR_MASK_SCLK_EXT, self);
      end
      else
      begin
        sclk = pick(pool, i_cfg[n].sclk_int_sel, `CNR_MASK_SCLK_INT, self);
      end
      src_e = edge_of(src, s_q.ctr[n].src_lvl, i_cfg[n].src_fall);
      gate_e = edge_of(gate, s_q.ctr[n].gate_lvl, i_cfg[n].gate_fall);
      arm_e = edge_of(arm, s_q.ctr[n].arm_lvl, 1'b0);
      sclk_e = edge_of(sclk, s_q.ctr[n].sclk_lvl, i_cfg[n].sclk_fall);
      s_d.ctr[n].src_lvl = src;
      s_d.ctr[n].gate_lvl = gate;
      s_d.ctr[n].aux_lvl = aux;
      s_d.ctr[n].arm_lvl = arm;
      s_d.ctr[n].sclk_lvl = sclk;
      // Pulse-width style measurements, and outputs that want a start trigger, wait for gate.
      gate_wait = (i_cfg[n].mode == CNR_ONE_TIME) ||
                  (i_cfg[n].mode == CNR_PULSE_GEN && i_cfg[n].start_req);
      s_d.out[n].gate_start = 1'b0;
      s_d.out[n].gate_stop = 1'b0;
      s_d.out[n].gate_latch = 1'b0;
      // Arm state machine; disarm wins over everything else.
      case (s_q.ctr[n].fsm)
        CNR_IDLE:
        begin
          if (!i_disarm[n] && (i_sw_arm[n] || (i_cfg[n].hardware_arm_input_en && arm_e)))
          begin
            s_d.ctr[n].fsm = gate_wait ? CNR_WAIT : CNR_RUN;
          end
        end
        CNR_WAIT:
        begin
          if (i_disarm[n])
          begin
            s_d.ctr[n].fsm = CNR_IDLE;
          end
          else if (gate_e)
          begin
            s_d.ctr[n].fsm = CNR_RUN;
            s_d.out[n].gate_start = 1'b1;
          end
        end
        CNR_RUN:
        begin
          if (i_disarm[n])
          begin
            s_d.ctr[n].fsm = CNR_IDLE;
          end
          else if (gate_e)
          begin
            s_d.out[n].gate_start = (i_cfg[n].gate_act == CNR_GATE_START);
            s_d.out[n].gate_stop = (i_cfg[n].gate_act == CNR_GATE_STOP);
            s_d.out[n].gate_latch = (i_cfg[n].gate_act == CNR_GATE_LATCH);
          end
        end
        default:
        begin
          s_d.ctr[n].fsm = CNR_IDLE;
        end
      endcase
      // Counting strobes only flow once the counter runs.
      s_d.out[n].src_tick = (s_q.ctr[n].fsm == CNR_RUN) && src_e;
      s_d.out[n].src_is_tb = (i_cfg[n].mode == CNR_PULSE_GEN) ||
                             (i_cfg[n].mode == CNR_ONE_TIME) ||
                             (i_cfg[n].mode == CNR_TWO_EDGE);
      if (i_cfg[n].dir_from_b &&
          (i_cfg[n].mode == CNR_EDGE_NB || i_cfg[n].mode == CNR_EDGE_BUF))
      begin
        s_d.out[n].up = s_d.out[n].b;
      end
      else
      begin
        s_d.out[n].up = i_cfg[n].dir_up;
      end
      s_d.out[n].aux_edge = (s_q.ctr[n].fsm != CNR_IDLE) &&
                            edge_of(aux, s_q.ctr[n].aux_lvl, 1'b0);
      s_d.out[n].armed = (s_d.ctr[n].fsm != CNR_IDLE);
      s_d.out[n].run = (s_d.ctr[n].fsm == CNR_RUN);
      s_d.out[n].sclk_tick = (s_q.ctr[n].fsm != CNR_IDLE) && sclk_e;
      // Overflow is sticky; a new overflow wins over a clear in the same cycle.
      if (s_d.out[n].sclk_tick && i_core[n].buf_full)
      begin
        s_d.out[n].overflow = 1'b1;
      end
      else if (i_ovf_clear[n])
      begin
        s_d.out[n].overflow = 1'b0;
      end
      // Internal output: generated pulses, or a pulse or toggle on terminal count.
      if (i_core[n].terminal_count)
      begin
        s_d.ctr[n].tog = ~s_q.ctr[n].tog;
      end
      if (i_cfg[n].mode == CNR_PULSE_GEN && !i_cfg[n].out_toggle)
      begin
        s_d.out[n].int_out = i_cfg[n].out_pol ^ i_core[n].gen_pulse;
      end
      else if (i_cfg[n].out_toggle)
      begin
        s_d.out[n].int_out = i_cfg[n].out_pol ^ s_d.ctr[n].tog;
      end
      else
      begin
        s_d.out[n].int_out = i_cfg[n].out_pol ^ i_core[n].terminal_count;
      end
    end
    // Terminal drivers; an unknown route code leaves the terminal undriven.
    for (int p = 0; p < `CNR_NPFI; p++)
    begin
      rt = i_pfi_route[p];
      s_d.pfi_oe_n[p] = 1'b0;
      s_d.pfi_out[p] = 1'b0;
      if (rt >= `CNR_ROUTE_SRC && rt < `CNR_ROUTE_GATE)
      begin
        s_d.pfi_out[p] = s_q.ctr[2'(rt - `CNR_ROUTE_SRC)].src_lvl;
      end
      else if (rt >= `CNR_ROUTE_GATE && rt < `CNR_ROUTE_Z)
      begin
        s_d.pfi_out[p] = s_q.ctr[2'(rt - `CNR_ROUTE_GATE)].gate_lvl;
      end
      else if (rt >= `CNR_ROUTE_Z && rt < `CNR_ROUTE_SCLK)
      begin
        s_d.pfi_out[p] = s_q.out[2'(rt - `CNR_ROUTE_Z)].z;
      end
      else if (rt >= `CNR_ROUTE_SCLK && rt < `CNR_ROUTE_INT_OUT)
      begin
        s_d.pfi_out[p] = ~s_q.ctr[2'(rt - `CNR_ROUTE_SCLK)].sclk_lvl;
      end
      else if (rt >= `CNR_ROUTE_INT_OUT && rt < `CNR_ROUTE_SQWAVE)
      begin
        s_d.pfi_out[p] = s_q.out[2'(rt - `CNR_ROUTE_INT_OUT)].int_out;
      end
      else if (rt == `CNR_ROUTE_SQWAVE)
      begin
        s_d.pfi_out[p] = i_sys.sqwave;
      end
      else
      begin
        s_d.pfi_oe_n[p] = 1'b1;
      end
    end
  end

  // State register; terminals come out of reset undriven and counters disarmed.
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      s_q <= '0;
      s_q.pfi_oe_n <= '1;
      for (int n = 0; n < `CNR_NCTR; n++)
      begin
        s_q.ctr[n].fsm <= CNR_IDLE;
      end
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_ctr = s_q.out;
  assign o_pfi_out = s_q.pfi_out;
  assign o_pfi_oe_n = s_q.pfi_oe_n;

  // Each check watches a counter or terminal that the bench drives; all instances share logic.
  a_tick_needs_run: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_ctr[0].src_tick |-> $past(s_q.ctr[0].fsm) == CNR_RUN)
    else $error("Count tick seen while the counter was not running.");

  a_buf_arm_run: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (s_q.ctr[0].fsm == CNR_IDLE && i_sw_arm[0] && !i_disarm[0] &&
     i_cfg[0].mode == CNR_EDGE_BUF) |=> (s_q.ctr[0].fsm == CNR_RUN) && o_ctr[0].run)
    else $error("Buffered edge count did not start on arm.");

  a_width_arm_wait: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (s_q.ctr[2].fsm == CNR_IDLE && i_sw_arm[2] && !i_disarm[2] &&
     i_cfg[2].mode == CNR_ONE_TIME) |=> s_q.ctr[2].fsm == CNR_WAIT ##0 o_ctr[2].armed)
    else $error("Pulse-width measurement did not wait for gate after arm.");

  a_ovf_sticky: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (o_ctr[3].overflow && !i_ovf_clear[3]) |=> o_ctr[3].overflow)
    else $error("Overflow flag dropped without a clear.");

  a_ovf_on_full: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (o_ctr[3].sclk_tick && $past(i_core[3].buf_full)) |-> o_ctr[3].overflow)
    else $error("Sample clock on a full buffer did not flag overflow.");

  a_pfi_idle_oe: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_pfi_route[0] == `CNR_ROUTE_NONE) |=> o_pfi_oe_n[0])
    else $error("Unrouted terminal is being driven.");

  a_sclk_invert: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_pfi_route[11] == (`CNR_ROUTE_SCLK + 5'h03)) |=>
      (!o_pfi_oe_n[11] && o_pfi_out[11] == !$past(s_q.ctr[3].sclk_lvl)))
    else $error("Sample clock on terminal is not inverted.");

  a_toggle_on_tc: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_core[1].terminal_count && i_cfg[1].out_toggle && $past(i_cfg[1].out_toggle) &&
     $stable(i_cfg[1].out_pol)) |=> o_ctr[1].int_out != $past(o_ctr[1].int_out))
    else $error("Internal output did not toggle on terminal count.");

endmodule

// ===== cnr_field_model.sv
// Model of the terminals and internal timing sources around the routing block.
`timescale 1ns/1ps
`include "cnr_map.svh"

module cnr_field_model
  import cnr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [`CNR_NPFI-1:0] i_ext_pfi,
  input wire logic [`CNR_NPFI-1:0] i_pfi_out,
  input wire logic [`CNR_NPFI-1:0] i_pfi_oe_n,
  input wire cnr_sys_s i_trig,
  output logic [`CNR_NPFI-1:0] o_pfi,
  output cnr_sys_s o_sys
);
  logic [5:0] tb_cnt_q;

  // Divider chain standing in for the timebases; only their relative rates matter here.
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      tb_cnt_q <= 6'h00;
    else
      tb_cnt_q <= tb_cnt_q + 6'h01;
  end

  // A terminal shows the block's drive while enabled, else the outside level.
  always_comb
  begin
    for (int k = 0; k < `CNR_NPFI; k++)
      o_pfi[k] = i_pfi_oe_n[k] ? i_ext_pfi[k] : i_pfi_out[k];
  end

  // Triggers and events come from the bench, timebases from the divider chain.
  always_comb
  begin
    o_sys = i_trig;
    o_sys.tb = tb_cnt_q;
  end
endmodule

// ===== cnr_routing_test.sv
// Self-checking bench for the counter signal routing block.
`timescale 1ns/1ps
`include "cnr_map.svh"

module cnr_routing_test
  import cnr_pkg::*;
;
  logic i_core_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [15:0] ext_pfi = '0;
  logic [15:0] pfi_line;
  logic i_pfi_filt_en = 1'b0;
  logic [15:0][4:0] i_pfi_route = '0;
  cnr_sys_s trig = '0;
  cnr_sys_s sys;
  cnr_cfg_s [3:0] i_cfg = '0;
  cnr_core_s [3:0] i_core = '0;
  logic [3:0] i_sw_arm = '0;
  logic [3:0] i_disarm = '0;
  logic [3:0] i_ovf_clear = '0;
  cnr_out_s [3:0] o_ctr;
  logic [15:0] o_pfi_out;
  logic [15:0] o_pfi_oe_n;
  int n_mismatch = 0;
  int total_checks = 0;

  // Clock at 10 MHz.
  always #50 i_core_clk = ~i_core_clk;

  cnr_field_model cnr_field_model_inst (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_ext_pfi(ext_pfi), .i_pfi_out(o_pfi_out), .i_pfi_oe_n(o_pfi_oe_n), .i_trig(trig),
    .o_pfi(pfi_line), .o_sys(sys));

  cnr_routing cnr_routing_inst (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_pfi(pfi_line),
    .i_pfi_filt_en(i_pfi_filt_en), .i_pfi_route(i_pfi_route), .i_sys(sys), .i_cfg(i_cfg),
    .i_core(i_core), .i_sw_arm(i_sw_arm), .i_disarm(i_disarm), .i_ovf_clear(i_ovf_clear),
    .o_ctr(o_ctr), .o_pfi_out(o_pfi_out), .o_pfi_oe_n(o_pfi_oe_n));

  // Prints the counts and the verdict, then stops the run.
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL at %0t: flag is %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic check_vec(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL at %0t: terminals are %h, expected %h", $time, got, exp);
    end
  endtask

  // Waits whole cycles, then samples once the edge's updates have landed.
  task automatic step(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task automatic set_pfi(input int k, input logic v);
    @(posedge i_core_clk);
    ext_pfi[k] <= v;
  endtask

  // Software arm or disarm as a one-cycle pulse.
  task automatic arm(input int c, input logic on);
    @(posedge i_core_clk);
    if (on)
      i_sw_arm[c] <= 1'b1;
    else
      i_disarm[c] <= 1'b1;
    @(posedge i_core_clk);
    i_sw_arm[c] <= 1'b0;
    i_disarm[c] <= 1'b0;
    step(1);
  endtask

  task automatic pulse_tc(input int c);
    @(posedge i_core_clk);
    i_core[c].terminal_count <= 1'b1;
    @(posedge i_core_clk);
    i_core[c].terminal_count <= 1'b0;
  endtask

  // Watches one pulse output from now through lim edges; a pulse launched by the
  // edge just passed stands only until the next one, so the current cycle is looked at too.
  task automatic expect_ev(input int c, input int f, input int lim, input logic exp);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i <= lim; i++)
    begin
      if (i > 0)
        @(posedge i_core_clk);
      #1;
      case (f)
        0: seen = seen | o_ctr[c].src_tick;
        1: seen = seen | o_ctr[c].gate_start;
        2: seen = seen | o_ctr[c].sclk_tick;
        4: seen = seen | o_ctr[c].gate_stop;
        5: seen = seen | o_ctr[c].gate_latch;
        default: seen = seen | o_ctr[c].aux_edge;
      endcase
    end
    check_bit(seen, exp);
  endtask

  // Main sequence: each group exercises one counter feature through the ports.
  initial
  begin
    repeat (8) @(posedge i_core_clk);
    i_reset <= 1'b0;
    i_cfg[0].mode <= CNR_EDGE_BUF;
    step(1);
    check_bit(o_ctr[0].armed, 1'b0);
    check_vec(o_pfi_oe_n, 16'hFFFF);
    set_pfi(0, 1'b1);
    expect_ev(0, 0, 8, 1'b0);
    set_pfi(0, 1'b0);
    arm(0, 1'b1);
    check_bit(o_ctr[0].run, 1'b1);
    set_pfi(0, 1'b1);
    expect_ev(0, 0, 8, 1'b1);
    check_bit(o_ctr[0].src_is_tb, 1'b0);
    i_cfg[0].src_sel <= 6'h10;
    expect_ev(0, 0, 8, 1'b1);
    i_cfg[0].dir_from_b <= 1'b1;
    i_cfg[0].b_sel <= 6'h01;
    set_pfi(1, 1'b1);
    step(8);
    check_bit(o_ctr[0].up, 1'b1);
    set_pfi(1, 1'b0);
    step(8);
    check_bit(o_ctr[0].up, 1'b0);
    check_bit(o_ctr[0].b, 1'b0);
    check_bit(o_ctr[0].a, 1'b1);
    // Another counter's terminal count as source; the counter's own is refused.
    i_cfg[1].mode <= CNR_EDGE_NB;
    i_cfg[1].src_sel <= 6'h20;
    arm(1, 1'b1);
    pulse_tc(0);
    expect_ev(1, 0, 6, 1'b1);
    i_cfg[1].src_sel <= 6'h21;
    pulse_tc(1);
    expect_ev(1, 0, 6, 1'b0);
    // Pulse-width style wait for a gate edge, then an output op with start trigger.
    i_cfg[2].mode <= CNR_ONE_TIME;
    i_cfg[2].gate_sel <= 6'h02;
    i_cfg[2].gate_act <= CNR_GATE_START;
    arm(2, 1'b1);
    check_bit(o_ctr[2].run, 1'b0);
    set_pfi(2, 1'b1);
    expect_ev(2, 1, 8, 1'b1);
    check_bit(o_ctr[2].run, 1'b1);
    arm(2, 1'b0);
    i_cfg[2].mode <= CNR_PULSE_GEN;
    i_cfg[2].start_req <= 1'b1;
    i_cfg[2].gate_sel <= 6'h1A;
    arm(2, 1'b1);
    check_bit(o_ctr[2].run, 1'b0);
    trig.ao_sclk <= 1'b1;
    expect_ev(2, 1, 4, 1'b1);
    check_bit(o_ctr[2].src_is_tb, 1'b1);
    i_pfi_route[9] <= 5'h07;
    step(3);
    check_bit(o_pfi_oe_n[9], 1'b0);
    check_bit(o_pfi_out[9], 1'b1);
    i_cfg[2].aux_sel <= 6'h30;
    trig.ao_sclk <= 1'b0;
    step(2);
    trig.ao_sclk <= 1'b1;
    expect_ev(2, 3, 6, 1'b1);
    // A running counter's gate edge stops or latches as configured.
    i_cfg[2].gate_act <= CNR_GATE_STOP;
    trig.ao_sclk <= 1'b0;
    step(2);
    trig.ao_sclk <= 1'b1;
    expect_ev(2, 4, 4, 1'b1);
    i_cfg[2].gate_act <= CNR_GATE_LATCH;
    trig.ao_sclk <= 1'b0;
    step(2);
    trig.ao_sclk <= 1'b1;
    expect_ev(2, 5, 4, 1'b1);
    // Sample clock from an internal source with a full buffer, then falling edges.
    i_cfg[3].mode <= CNR_EDGE_BUF;
    i_cfg[3].sclk_int_sel <= 6'h1B;
    i_core[3].buf_full <= 1'b1;
    arm(3, 1'b1);
    trig.di_sclk <= 1'b1;
    expect_ev(3, 2, 4, 1'b1);
    check_bit(o_ctr[3].overflow, 1'b1);
    trig.di_sclk <= 1'b0;
    expect_ev(3, 2, 4, 1'b0);
    i_pfi_route[11] <= 5'h10;
    i_ovf_clear[3] <= 1'b1;
    step(1);
    i_ovf_clear[3] <= 1'b0;
    step(3);
    check_bit(o_ctr[3].overflow, 1'b0);
    check_bit(o_pfi_out[11], 1'b1);
    i_cfg[3].sclk_fall <= 1'b1;
    i_core[3].buf_full <= 1'b0;
    trig.di_sclk <= 1'b1;
    step(3);
    trig.di_sclk <= 1'b0;
    expect_ev(3, 2, 4, 1'b1);
    check_bit(o_ctr[3].overflow, 1'b0);
    // Internal output in toggle mode follows the count of terminal counts.
    i_cfg[1].out_toggle <= 1'b1;
    step(3);
    check_bit(o_ctr[1].int_out, 1'b1);
    pulse_tc(1);
    step(3);
    check_bit(o_ctr[1].int_out, 1'b0);
    i_cfg[1].out_pol <= 1'b1;
    step(3);
    check_bit(o_ctr[1].int_out, 1'b1);
    // Generated pulses rise on the internal output and hardware-arm another counter.
    arm(0, 1'b0);
    i_cfg[0].hardware_arm_input_en <= 1'b1;
    i_cfg[0].arm_sel <= 6'h29;
    i_cfg[1].mode <= CNR_PULSE_GEN;
    i_cfg[1].out_toggle <= 1'b0;
    i_cfg[1].out_pol <= 1'b0;
    step(4);
    i_core[1].gen_pulse <= 1'b1;
    i_pfi_route[12] <= 5'h12;
    step(6);
    check_bit(o_ctr[1].int_out, 1'b1);
    check_bit(o_ctr[0].armed, 1'b1);
    check_bit(o_pfi_out[12], 1'b1);
    // Counter 0 index input follows terminal 0, which stands high.
    i_pfi_route[13] <= 5'h09;
    step(3);
    check_bit(o_pfi_oe_n[13], 1'b0);
    check_bit(o_pfi_out[13], 1'b1);
    // A one-cycle glitch is swallowed by the filter; a held level passes.
    i_cfg[0].src_sel <= 6'h05;
    i_pfi_filt_en <= 1'b1;
    step(6);
    set_pfi(5, 1'b1);
    set_pfi(5, 1'b0);
    expect_ev(0, 0, 10, 1'b0);
    set_pfi(5, 1'b1);
    expect_ev(0, 0, 12, 1'b1);
    close_out();
  end

  // Watchdog: the sequence needs well under a thousand cycles.
  initial
  begin
    #500000;
    n_mismatch++;
    close_out();
  end
endmodule
